// ---- perf_event_pkg.sv ----
// constants and carrier types for the cache and tlb event counter
// assumes a 32-bit apb register bus and one event source group per core
package perf_event_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register map, byte addresses
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_CNT_LO = 8'h08;
   localparam logic [7:0] OFF_CNT_HI = 8'h0C;

   // control field positions
   localparam int CTRL_EVT_LSB   = 0;
   localparam int CTRL_UMASK_LSB = 8;
   localparam int CTRL_EN_BIT    = 16;

   // status field positions
   localparam int STAT_VALID_BIT  = 0;
   localparam int STAT_HALTED_BIT = 1;
   localparam int STAT_OVF_BIT    = 2;

   // reset values
   localparam logic [7:0]  EVT_RST   = 8'h00;
   localparam logic [7:0]  UMASK_RST = 8'h00;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // event numbers
   localparam logic [7:0] EV_L2_DATA  = 8'h26;
   localparam logic [7:0] EV_L2_WRITE = 8'h27;
   localparam logic [7:0] EV_L1_WB    = 8'h28;
   localparam logic [7:0] EV_LLC      = 8'h2E;
   localparam logic [7:0] EV_UNHALTED = 8'h3C;
   localparam logic [7:0] EV_TLB_MISS = 8'h49;

   // unit masks
   localparam logic [7:0] UM_00 = 8'h00;
   localparam logic [7:0] UM_01 = 8'h01;
   localparam logic [7:0] UM_02 = 8'h02;
   localparam logic [7:0] UM_04 = 8'h04;
   localparam logic [7:0] UM_08 = 8'h08;
   localparam logic [7:0] UM_0E = 8'h0E;
   localparam logic [7:0] UM_0F = 8'h0F;
   localparam logic [7:0] UM_10 = 8'h10;
   localparam logic [7:0] UM_20 = 8'h20;
   localparam logic [7:0] UM_40 = 8'h40;
   localparam logic [7:0] UM_80 = 8'h80;
   localparam logic [7:0] UM_E0 = 8'hE0;
   localparam logic [7:0] UM_F0 = 8'hF0;
   localparam logic [7:0] UM_FF = 8'hFF;

   // line state bit order within a 4-bit state vector
   localparam int ST_I = 0;
   localparam int ST_S = 1;
   localparam int ST_E = 2;
   localparam int ST_M = 3;

   ////////////////////////////////////////////////////////////////////////
   // events raised by the cache hierarchy and page walker, one cycle each except thread_halted and walk_active, which are levels
   typedef struct packed {
      logic [3:0] demand_load_state;   // l2 demand data load, one-hot state
      logic [3:0] prefetch_load_state; // l2 prefetch data load, one-hot state
      logic       prefetch_is_rfo;     // prefetch above is for ownership
      logic [3:0] store_rfo_state;     // l2 store ownership request
      logic       store_rfo_prefetch;  // that request came from a prefetcher
      logic [3:0] lock_rfo_state;      // l2 demand locked ownership request
      logic [3:0] writeback_state;     // l1 writeback into l2
      logic       llc_reference;
      logic       llc_miss;
      logic       thread_halted;       // level
      logic       tsc_tick;            // time_stamp_counter rate pulse
      logic       walk_start;          // second_level_tlb miss starts a walk
      logic       walk_done;
      logic       walk_active;         // level, high in every walk cycle
      logic       second_level_tlb_hit;            // first level miss, second_level_tlb hit
      logic       pde_miss;            // low address part miss
   } event_in_t;

endpackage : perf_event_pkg

// ---- cache_tlb_event_select_decode.sv ----
// event selection and counting for the cache and tlb event group
// assumes apb master on pclk; event inputs synchronous to pclk, one-hot states
//
// Overview of operation
// - 26H masks 20/40/80 count prefetch S/E/M
// - prefetch ownership on shared line is miss
// - 26H F0H counts every prefetch request
// - 26H FFH counts demand and prefetch requests
// - 27H masks 01/02/08 count store ownership I/S/M
// - 27H 0EH counts store ownership hits
// - 27H 0FH counts all store ownership
// - store ownership events count demand requests only
// - 27H masks 10/20/40/80 count locked ownership
// - 27H E0H counts locked ownership hits
// - 27H F0H counts all locked ownership
// - 28H masks 01/02/04/08 count writebacks by state
// - 28H 0FH counts every writeback
// - 2EH 02H references, 01H misses
// - 3CH 00H counts unhalted core cycles
// - 3CH 01H counts tsc rate while unhalted
// - 49H 01H counts misses starting walk
// - 49H 02H counts completed walks
// - 49H 04H counts page walk cycles
// - 49H 10H counts second level tlb hits
// - 49H 20H counts low address misses
module cache_tlb_event_select_decode #(
   parameter int CNT_W = 48
) (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   input  wire logic [3:0]                  pstrb,
   output logic                             pready,
   output logic [31:0]                      prdata,
   output logic                             pslverr,
   input  wire perf_event_pkg::event_in_t   events,
   output logic                             count_pulse,
   output logic [CNT_W-1:0]                 count_value
);

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0]       evt_r;
   logic [7:0]       umask_r;
   logic             en_r;
   logic [CNT_W-1:0] cnt_r;
   logic             ovf_r;
   logic             pready_r;
   logic [31:0]      prdata_r;
   logic             pslverr_r;
   logic             pulse_r;

   ////////////////////////////////////////////////////////////////////////
   // apb decode
   wire setup_phase = psel & ~penable;
   wire access_done = psel & penable & pready_r;
   wire hit_ctrl    = (paddr == perf_event_pkg::OFF_CTRL);
   wire hit_status  = (paddr == perf_event_pkg::OFF_STATUS);
   wire hit_lo      = (paddr == perf_event_pkg::OFF_CNT_LO);
   wire hit_hi      = (paddr == perf_event_pkg::OFF_CNT_HI);
   wire mapped      = hit_ctrl | hit_status | hit_lo | hit_hi;
   wire wr_ctrl     = access_done & pwrite & hit_ctrl;
   wire wr_lo       = access_done & pwrite & hit_lo;
   wire wr_hi       = access_done & pwrite & hit_hi;
   wire wr_status   = access_done & pwrite & hit_status;

   // counter split across two words
   logic [63:0] cnt_wide;
   assign cnt_wide = 64'(cnt_r);

   logic [31:0] ctrl_word;
   logic [31:0] status_word;
   logic [31:0] rd_mux;

   assign ctrl_word = perf_event_pkg::DATA_ZERO
                    | (32'(evt_r)   << perf_event_pkg::CTRL_EVT_LSB)
                    | (32'(umask_r) << perf_event_pkg::CTRL_UMASK_LSB)
                    | (32'(en_r)    << perf_event_pkg::CTRL_EN_BIT);

   wire combo_ok;
   assign status_word = perf_event_pkg::DATA_ZERO
                    | (32'(combo_ok)              << perf_event_pkg::STAT_VALID_BIT)
                    | (32'(events.thread_halted)  << perf_event_pkg::STAT_HALTED_BIT)
                    | (32'(ovf_r)                 << perf_event_pkg::STAT_OVF_BIT);

   assign rd_mux = hit_ctrl   ? ctrl_word    :
                   hit_status ? status_word  :
                   hit_lo     ? cnt_wide[31:0] :
                   hit_hi     ? cnt_wide[63:32] :
                                perf_event_pkg::DATA_ZERO;

   // byte-lane merge for control and counter writes
   logic [31:0] ctrl_merged;
   logic [31:0] lo_merged;
   logic [31:0] hi_merged;
   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++) begin : g_lane
         assign ctrl_merged[gb*8 +: 8] = pstrb[gb] ? pwdata[gb*8 +: 8] : ctrl_word[gb*8 +: 8];
         assign lo_merged[gb*8 +: 8]   = pstrb[gb] ? pwdata[gb*8 +: 8] : cnt_wide[gb*8 +: 8];
         assign hi_merged[gb*8 +: 8]   = pstrb[gb] ? pwdata[gb*8 +: 8] : cnt_wide[32+gb*8 +: 8];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // listed event and mask pairs
   wire is_26 = (evt_r == perf_event_pkg::EV_L2_DATA);
   wire is_27 = (evt_r == perf_event_pkg::EV_L2_WRITE);
   wire is_28 = (evt_r == perf_event_pkg::EV_L1_WB);
   wire is_2e = (evt_r == perf_event_pkg::EV_LLC);
   wire is_3c = (evt_r == perf_event_pkg::EV_UNHALTED);
   wire is_49 = (evt_r == perf_event_pkg::EV_TLB_MISS);

   wire um_single = (umask_r == perf_event_pkg::UM_01) | (umask_r == perf_event_pkg::UM_02)
                  | (umask_r == perf_event_pkg::UM_04) | (umask_r == perf_event_pkg::UM_08);
   wire um_high   = (umask_r == perf_event_pkg::UM_10) | (umask_r == perf_event_pkg::UM_20)
                  | (umask_r == perf_event_pkg::UM_40) | (umask_r == perf_event_pkg::UM_80);

   wire ok_26 = is_26 & (um_single | um_high
              | (umask_r == perf_event_pkg::UM_0F)
              | (umask_r == perf_event_pkg::UM_F0)
              | (umask_r == perf_event_pkg::UM_FF));
   wire ok_27 = is_27 & (((umask_r == perf_event_pkg::UM_01)
              | (umask_r == perf_event_pkg::UM_02) | (umask_r == perf_event_pkg::UM_08))
              | (umask_r == perf_event_pkg::UM_0E)
              | (umask_r == perf_event_pkg::UM_0F)
              | um_high
              | (umask_r == perf_event_pkg::UM_E0)
              | (umask_r == perf_event_pkg::UM_F0));
   wire ok_28 = is_28 & (um_single | (umask_r == perf_event_pkg::UM_0F));
   wire ok_2e = is_2e & ((umask_r == perf_event_pkg::UM_01)
              | (umask_r == perf_event_pkg::UM_02));
   wire ok_3c = is_3c & ((umask_r == perf_event_pkg::UM_00)
              | (umask_r == perf_event_pkg::UM_01));
   wire ok_49 = is_49 & ((umask_r == perf_event_pkg::UM_01)
              | (umask_r == perf_event_pkg::UM_02) | (umask_r == perf_event_pkg::UM_04)
              | (umask_r == perf_event_pkg::UM_10) | (umask_r == perf_event_pkg::UM_20));

   assign combo_ok = ok_26 | ok_27 | ok_28 | ok_2e | ok_3c | ok_49;

   ////////////////////////////////////////////////////////////////////////
   // per-event qualification
   // a prefetch for ownership that finds a shared line is reclassified as invalid
   wire       pf_s_rfo = events.prefetch_load_state[perf_event_pkg::ST_S]
                       & events.prefetch_is_rfo;
   logic [3:0] pf_state;
   assign pf_state = pf_s_rfo ? (4'b0001 << perf_event_pkg::ST_I)
                              : events.prefetch_load_state;

   // store ownership only counts demand requests
   logic [3:0] rfo_state;
   assign rfo_state = events.store_rfo_prefetch ? 4'b0000 : events.store_rfo_state;

   // union of per-state conditions picked by the mask
   wire hit_26 = |({pf_state, events.demand_load_state} & umask_r);
   wire hit_27 = |({events.lock_rfo_state, rfo_state} & umask_r);
   wire hit_28 = |(events.writeback_state & umask_r[3:0]);

   wire hit_2e = umask_r[1] ? events.llc_reference : events.llc_miss;

   wire unhalted = ~events.thread_halted;
   wire hit_3c = umask_r[0] ? (events.tsc_tick & unhalted)
                            : unhalted;

   logic hit_49;
   assign hit_49 = (umask_r == perf_event_pkg::UM_01) ? events.walk_start :
                   (umask_r == perf_event_pkg::UM_02) ? events.walk_done :
                   (umask_r == perf_event_pkg::UM_04) ? events.walk_active :
                   (umask_r == perf_event_pkg::UM_10) ? events.second_level_tlb_hit :
                   (umask_r == perf_event_pkg::UM_20) ? events.pde_miss :
                                                        1'b0;

   wire incr = en_r & ((ok_26 & hit_26) | (ok_27 & hit_27) | (ok_28 & hit_28)
                     | (ok_2e & hit_2e) | (ok_3c & hit_3c) | (ok_49 & hit_49));

   // counter next value; software write beats a same-cycle increment
   logic [CNT_W-1:0] cnt_nxt;
   logic [63:0]      cnt_load;
   assign cnt_load = wr_lo ? {cnt_wide[63:32], lo_merged}
                   : {hi_merged, cnt_wide[31:0]};
   wire cnt_wrap = incr & (&cnt_r);
   assign cnt_nxt = (wr_lo | wr_hi) ? cnt_load[CNT_W-1:0]
                  : incr            ? cnt_r + CNT_W'(1)
                  :                   cnt_r;

   ////////////////////////////////////////////////////////////////////////
   // state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_r   <= perf_event_pkg::EVT_RST;
         umask_r <= perf_event_pkg::UMASK_RST;
         en_r    <= 1'b0;
      end else if (wr_ctrl) begin
         evt_r   <= ctrl_merged[perf_event_pkg::CTRL_EVT_LSB +: 8];
         umask_r <= ctrl_merged[perf_event_pkg::CTRL_UMASK_LSB +: 8];
         en_r    <= ctrl_merged[perf_event_pkg::CTRL_EN_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r   <= '0;
         pulse_r <= 1'b0;
      end else begin
         cnt_r   <= cnt_nxt;
         pulse_r <= incr;
      end
   end

   // overflow flag: wrap sets, write-one clears, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_r <= 1'b0;
      end else if (cnt_wrap) begin
         ovf_r <= 1'b1;
      end else if (wr_status & pstrb[0] & pwdata[perf_event_pkg::STAT_OVF_BIT]) begin
         ovf_r <= 1'b0;
      end
   end

   // apb answer: ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         prdata_r  <= perf_event_pkg::DATA_ZERO;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= setup_phase;
         pslverr_r <= setup_phase & ~mapped;
         prdata_r  <= (setup_phase & ~pwrite) ? rd_mux : perf_event_pkg::DATA_ZERO;
      end
   end

   assign pready      = pready_r;
   assign prdata      = prdata_r;
   assign pslverr     = pslverr_r;
   assign count_pulse = pulse_r;
   assign count_value = cnt_r;

endmodule // cache_tlb_event_select_decode

// ---- cache_tlb_event_sva.sv ----
// concurrent checks on the ports of the cache and tlb event counter
// bound to the design top by the bench; one clock domain, pclk
module cache_tlb_event_sva #(
   parameter int CNT_W = 48
) (
   input wire logic                      pclk,
   input wire logic                      presetn,
   input wire logic                      psel,
   input wire logic                      penable,
   input wire logic                      pwrite,
   input wire logic [7:0]                paddr,
   input wire logic [31:0]               pwdata,
   input wire logic [3:0]                pstrb,
   input wire logic                      pready,
   input wire logic [31:0]               prdata,
   input wire logic                      pslverr,
   input wire perf_event_pkg::event_in_t events,
   input wire logic                      count_pulse,
   input wire logic [CNT_W-1:0]          count_value
);
   timeunit 1ns;
   timeprecision 100ps;

   perf_event_pkg::event_in_t ev_q;
   perf_event_pkg::event_in_t ev_clr;
   logic                      wr_q;
   wire logic                 mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C};

   // last cycle's events and whether a register write landed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_q <= '0;
         wr_q <= 1'b0;
      end else begin
         ev_q <= events;
         wr_q <= psel && penable && pwrite && pready;
      end
   end

   always_comb begin
      ev_clr = ev_q;
      ev_clr.thread_halted = 1'b0;
   end

   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////////
   chk_setup_ready: assert property (psel && !penable |=> pready)
      else $error("no ready in first access cycle");
   chk_ready_single: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   chk_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   chk_err_unmapped: assert property (pready |-> pslverr == !mapped)
      else $error("error flag does not match address map");
   chk_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0000_0000)
      else $error("read data not zero outside read");
   chk_count_step: assert property (
      count_pulse && !wr_q |-> count_value == $past(count_value) + 1'b1)
      else $error("counter did not step by one");
   chk_count_hold: assert property (
      !count_pulse && !wr_q |-> $stable(count_value))
      else $error("counter moved without a count");
   chk_halt_quiet: assert property (
      count_pulse |-> !ev_q.thread_halted || ev_clr != '0)
      else $error("count while halted with no event");

   cov_count: cover property (count_pulse);
   cov_err: cover property (pready && pslverr);
   cov_read: cover property (pready && !pwrite);
endmodule // cache_tlb_event_sva

// ---- event_source_model.sv ----
// cache hierarchy and page walker event source for the counter bench
// idle: thread halted, no pulses; bursts are 16 cycles then idle
module event_source_model (
   input  wire logic                pclk,
   output perf_event_pkg::event_in_t events
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      events = '0;
      events.thread_halted = 1'b1;
   end

   task automatic burst(input logic [7:0] evt);
      perf_event_pkg::event_in_t e;
      for (int i = 0; i < 17; i++) begin
         e = '0;
         e.thread_halted = 1'b1;
         if (i < 16) begin
            case (evt)
               perf_event_pkg::EV_L2_DATA: begin
                  if (i < 4) e.demand_load_state = 4'h1 << i;
                  else if (i < 8) e.prefetch_load_state = 4'h1 << (i - 4);
                  else if (i == 8) e.prefetch_load_state = 4'h2;
                  e.prefetch_is_rfo = (i == 8);
               end
               perf_event_pkg::EV_L2_WRITE: begin
                  if (i < 4) e.store_rfo_state = 4'h1 << i;
                  else if (i < 8) e.lock_rfo_state = 4'h1 << (i - 4);
                  else if (i == 8) e.store_rfo_state = 4'h2;
                  e.store_rfo_prefetch = (i == 8);
               end
               perf_event_pkg::EV_L1_WB: if (i < 4) e.writeback_state = 4'h1 << i;
               perf_event_pkg::EV_LLC: begin
                  e.llc_reference = (i < 3);
                  e.llc_miss = (i == 3) || (i == 4);
               end
               perf_event_pkg::EV_UNHALTED: begin
                  e.thread_halted = (i >= 8);
                  e.tsc_tick = (i % 4 == 0);
               end
               perf_event_pkg::EV_TLB_MISS: begin
                  e.walk_start = (i == 0);
                  e.walk_active = (i >= 1) && (i <= 5);
                  e.walk_done = (i == 5);
                  e.second_level_tlb_hit = (i == 6) || (i == 7);
                  e.pde_miss = (i >= 8) && (i <= 10);
               end
               default: ;
            endcase
         end
         @(posedge pclk);
         events <= e;
      end
   endtask
endmodule // event_source_model

// ---- tb_top.sv ----
// bench for the cache and tlb event counter: apb master and event bursts
// assumes the event source model drives bursts of known counts
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic                      pclk = 1'b0;
   logic                      presetn = 1'b0;
   logic                      psel = 1'b0;
   logic                      penable = 1'b0;
   logic                      pwrite = 1'b0;
   logic [7:0]                paddr = 8'h00;
   logic [31:0]               pwdata = 32'h0000_0000;
   logic [3:0]                pstrb = 4'hF;
   logic                      pready;
   logic [31:0]               prdata;
   logic                      pslverr;
   perf_event_pkg::event_in_t events;
   logic [31:0]               rd;
   logic                      er;
   int                        err_count = 0;
   int                        num_checks = 0;
   // event, unit mask, expected count after one burst
   logic [7:0]                tab [32][3] = '{
      '{8'h26, 8'h20, 8'h01}, '{8'h26, 8'h40, 8'h01}, '{8'h26, 8'h80, 8'h01},
      '{8'h26, 8'hF0, 8'h05}, '{8'h26, 8'hFF, 8'h09},
      '{8'h27, 8'h01, 8'h01}, '{8'h27, 8'h02, 8'h01}, '{8'h27, 8'h08, 8'h01},
      '{8'h27, 8'h0E, 8'h03}, '{8'h27, 8'h0F, 8'h04}, '{8'h27, 8'h04, 8'h00},
      '{8'h27, 8'h10, 8'h01}, '{8'h27, 8'h20, 8'h01}, '{8'h27, 8'h40, 8'h01},
      '{8'h27, 8'h80, 8'h01}, '{8'h27, 8'hE0, 8'h03}, '{8'h27, 8'hF0, 8'h04},
      '{8'h28, 8'h01, 8'h01}, '{8'h28, 8'h02, 8'h01}, '{8'h28, 8'h04, 8'h01},
      '{8'h28, 8'h08, 8'h01}, '{8'h28, 8'h0F, 8'h04},
      '{8'h2E, 8'h02, 8'h03}, '{8'h2E, 8'h01, 8'h02}, '{8'h2E, 8'h03, 8'h00},
      '{8'h3C, 8'h00, 8'h08}, '{8'h3C, 8'h01, 8'h02},
      '{8'h49, 8'h01, 8'h01}, '{8'h49, 8'h02, 8'h01}, '{8'h49, 8'h04, 8'h05},
      '{8'h49, 8'h10, 8'h02}, '{8'h49, 8'h20, 8'h03}};

   always #5 pclk = ~pclk;

   cache_tlb_event_select_decode #(.CNT_W(48)) cache_tlb_event_select_decode_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .events(events), .count_pulse(), .count_value());
   event_source_model event_source_model_inst (.pclk(pclk), .events(events));

   ////////////////////////////////////////////////////////////////////////
   // setup, then access held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic run(input logic en, input logic [7:0] ev, input logic [7:0] um);
      apb(1'b1, perf_event_pkg::OFF_CTRL, {15'h0000, en, um, ev});
      apb(1'b1, perf_event_pkg::OFF_CNT_LO, 32'h0000_0000);
      apb(1'b1, perf_event_pkg::OFF_CNT_HI, 32'h0000_0000);
      event_source_model_inst.burst(ev);
      apb(1'b0, perf_event_pkg::OFF_CNT_LO, 32'h0000_0000);
   endtask

   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 32; i++) begin
         run(1'b1, tab[i][0], tab[i][1]);
         chk(rd, {24'h00_0000, tab[i][2]});
      end
      run(1'b0, perf_event_pkg::EV_UNHALTED, perf_event_pkg::UM_00);
      chk(rd, 32'h0000_0000);
      apb(1'b0, perf_event_pkg::OFF_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0003);
      apb(1'b0, perf_event_pkg::OFF_CNT_HI, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk({31'h0000_0000, er}, 32'h0000_0001);
      chk(rd, 32'h0000_0000);
      test_done();
   end

   initial begin
      repeat (30000) @(posedge pclk);
      err_count++;
      test_done();
   end
endmodule // tb_top

bind cache_tlb_event_select_decode cache_tlb_event_sva #(.CNT_W(CNT_W)) cache_tlb_event_sva_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .events(events), .count_pulse(count_pulse),
   .count_value(count_value));
